// >>> dv/free_running_timer_counter_tb.sv
`timescale 1ns/1ps
module free_running_timer_counter_tb;
  logic        clk_sys_i = 0;
  logic        reset_i = 1;
  logic [3:0]  avs_address_i = 0;
  logic        avs_read_i = 0;
  logic        avs_write_i = 0;
  logic [31:0] avs_writedata_i = 0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        cpu_tick_i = 0;
  logic        halt_i = 0;
  logic        global_irq_mask_i = 1;
  logic        ext_clk_bonded_i = 1;
  logic        external_clock_pin_i = 0;
  logic        overflow_irq_o;
  logic        irq_o;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  frt_timer dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .cpu_tick_i(cpu_tick_i), .halt_i(halt_i),
    .global_irq_mask_i(global_irq_mask_i), .ext_clk_bonded_i(ext_clk_bonded_i),
    .external_clock_pin_i(external_clock_pin_i), .overflow_irq_o(overflow_irq_o),
    .irq_o(irq_o));
  always #20 clk_sys_i = ~clk_sys_i;
  task automatic final_report();
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request is held until waitrequest is sampled low; one idle edge between requests
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_read_i <= !w;
    avs_write_i <= w;
    do begin
      @(posedge clk_sys_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_read_i <= 0;
    avs_write_i <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    bus(0, a, 0, q);
    chk(nm, q, e);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1, a, d, q);
  endtask
  task automatic cc(input logic [15:0] e);
    rd(0, e[15:8], "count_high");
    rd(1, e[7:0], "count_low");
  endtask
  // Multiples of eight ticks keep the result free of prescaler phase
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk_sys_i) cpu_tick_i <= 1;
      @(posedge clk_sys_i) cpu_tick_i <= 0;
    end
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic ep(input int n);
    repeat (2 * n) begin
      repeat (6) @(posedge clk_sys_i);
      external_clock_pin_i <= ~external_clock_pin_i;
    end
    repeat (6) @(posedge clk_sys_i);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  initial begin
    wt(2);
    reset_i <= 0;
    cc(16'hfffc);
    rd(2, 8'hff, "alt_high");
    rd(3, 8'hfc, "alt_low");
    rd(0, 8'hff, "count_high");
    tk(8);
    rd(0, 8'h00, "count_high");
    rd(1, 8'hfc, "frozen_low");
    rd(1, 8'h00, "live_low");
    rd(4, 8'h80, "status");
    rd(3, 8'h00, "alt_low");
    rd(4, 8'h80, "status");
    rd(1, 8'h00, "count_low");
    rd(4, 8'h00, "status");
    wr(5, 8'h01);
    tk(16);
    cc(16'h0004);
    wr(5, 8'h02);
    tk(16);
    cc(16'h0006);
    wr(5, 8'h00);
    tk(16);
    cc(16'h000e);
    wr(3, 8'h00);
    cc(16'hfffc);
    wr(5, 8'h08);
    tk(8);
    chk("ovf_irq", overflow_irq_o, 0);
    rd(4, 8'h80, "status");
    global_irq_mask_i <= 0;
    wt(2);
    chk("ovf_irq", overflow_irq_o, 1);
    chk("irq", irq_o, 0);
    wr(6, 8'h01);
    wt(2);
    chk("irq", irq_o, 1);
    wr(7, 8'h01);
    wt(2);
    chk("irq", irq_o, 0);
    wr(1, 8'h00);
    wt(2);
    chk("ovf_irq", overflow_irq_o, 0);
    cc(16'hfffc);
    halt_i <= 1;
    tk(8);
    cc(16'hfffc);
    halt_i <= 0;
    tk(8);
    cc(16'h0000);
    wr(5, 8'h07);
    cpu_tick_i <= 1;
    ep(3);
    cc(16'h0003);
    wr(5, 8'h03);
    ep(3);
    cc(16'h0006);
    external_clock_pin_i <= 1;
    wt(8);
    ext_clk_bonded_i <= 0;
    ep(3);
    cc(16'h0006);
    final_report();
  end
endmodule

// >>> rtl/frt_pkg.sv
package frt_pkg;
  // Register word offsets on the Avalon-MM slave, one aligned word each
  localparam logic [3:0] OFS_COUNT_HIGH = 4'h0;
  localparam logic [3:0] OFS_COUNT_LOW  = 4'h1;
  localparam logic [3:0] OFS_ALT_HIGH   = 4'h2;
  localparam logic [3:0] OFS_ALT_LOW    = 4'h3;
  localparam logic [3:0] OFS_STATUS     = 4'h4;
  localparam logic [3:0] OFS_CONTROL    = 4'h5;
  localparam logic [3:0] OFS_IRQ_MASK   = 4'h6;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h7;

  localparam logic [15:0] COUNT_RESET   = 16'hfffc;
  localparam logic [15:0] COUNT_TOP     = 16'hffff;

  // Control and status register field positions
  localparam int CTRL_CLK_SEL_LO = 0;
  localparam int CTRL_CLK_SEL_HI = 1;
  localparam int CTRL_EXT_EDGE   = 2;
  localparam int CTRL_OVF_IE     = 3;
  localparam int STAT_OVF        = 7;

  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  typedef enum logic [1:0] {
    CLR_IDLE  = 2'b01,
    CLR_ARMED = 2'b10
  } frt_clr_type;

  typedef struct packed {
    logic [15:0] count;
    logic [2:0]  presc;
    logic [7:0]  low_buf;
    logic        low_frozen;
    logic        ovf;
    frt_clr_type clr_st;
    logic [1:0]  clk_sel;
    logic        ext_edge;
    logic        ovf_ie;
    logic        irq_mask;
    logic        irq_stat;
    logic [2:0]  ext_sync;
    logic        cpu_tick_q;
    logic        ack;
    logic [31:0] rdata;
    logic        irq;
  } frt_state_type;
endpackage

// >>> rtl/frt_timer.sv
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
// Operation
// [RL1] Free running sixteen bit up counter, bytewise
// [RL2] Prescaler divides CPU clock by 2, 4, 8
// [RL3] Select value three counts external clock edges
// [RL4] Low byte writes reload counter to FFFCh
// [RL5] Counter resets to FFFCh in all modes
// [RL6] Main and alternate views return same count
// [RL7] High byte read captures low byte
// [RL8] Buffered low byte frozen until low read
// [RL9] Unpaired low read returns live byte
// [RL10] Wrap FFFFh to 0000h sets overflow flag
// [RL11] Interrupt needs enable and clear global mask; irq_o ignores both and is gated only by irq_mask
// [RL12] Status read then main low access clears
// [RL13] Alternate low access never clears flag
// [RL14] Wait mode leaves counter running
// [RL15] Halt stops counter; resumes held count
// [RL16] Edge select picks rising or falling edge
// [RL17] Updates happen on CPU clock tick only
// [RL18] External clock slower than quarter CPU clock
// [RL19] Unbonded timer input reads as one
module frt_timer (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        cpu_tick_i,
  input  wire logic        halt_i,
  input  wire logic        global_irq_mask_i,
  input  wire logic        ext_clk_bonded_i,
  input  wire logic        external_clock_pin_i,
  output logic             overflow_irq_o,
  output logic             irq_o
);
  import frt_pkg::*;

  frt_state_type r;
  frt_state_type next_r;

  logic       ext_level;
  logic       ext_rise;
  logic       ext_fall;
  logic       ext_hit;
  logic       div_hit;
  logic       adv;
  logic       req;
  logic       rd;
  logic       wr;
  logic [7:0] live_low;

  // Unbonded pin is pulled to one so it never produces an edge
  assign ext_level = ext_clk_bonded_i ? external_clock_pin_i : 1'b1; // [RL19]

  always_comb begin
    next_r   = r;
    req      = (avs_read_i | avs_write_i) & ~r.ack;
    rd       = req & avs_read_i;
    wr       = req & avs_write_i & avs_byteenable_i[0];
    live_low = r.count[7:0];
    ext_rise = r.ext_sync[1] & ~r.ext_sync[2];
    ext_fall = ~r.ext_sync[1] & r.ext_sync[2];
    ext_hit  = r.ext_edge ? ext_rise : ext_fall; // [RL16]
    case (r.clk_sel)
      CLK_DIV2: div_hit = r.presc[0]; // [RL2]
      CLK_DIV4: div_hit = &r.presc[1:0]; // [RL2]
      CLK_DIV8: div_hit = &r.presc; // [RL2]
      default:  div_hit = 1'b0;
    endcase
    // Every update waits for the CPU clock tick registered one cycle earlier; halt freezes it
    adv = r.cpu_tick_q & ~halt_i & ((r.clk_sel == CLK_EXT) ? ext_hit : div_hit); // [RL3] [RL14] [RL15] [RL17]
    next_r.ext_sync = {r.ext_sync[1:0], ext_level};
    next_r.cpu_tick_q = cpu_tick_i;
    if (r.cpu_tick_q && !halt_i) begin
      next_r.presc = r.presc + 3'h1; // [RL15]
    end
    if (adv) begin
      next_r.count = r.count + 16'h0001; // [RL1]
      if (r.count == COUNT_TOP) begin
        next_r.ovf = 1'b1; // [RL10]
        next_r.irq_stat = 1'b1;
      end
    end
    next_r.ack   = req;
    next_r.rdata = 32'h0;
    if (rd) begin
      case (avs_address_i)
        OFS_COUNT_HIGH, OFS_ALT_HIGH: begin
          next_r.rdata[7:0] = r.count[15:8]; // [RL6]
          if (!r.low_frozen) begin
            next_r.low_buf    = live_low; // [RL7]
            next_r.low_frozen = 1'b1; // [RL8]
          end
        end
        OFS_COUNT_LOW, OFS_ALT_LOW: begin
          next_r.rdata[7:0] = r.low_frozen ? r.low_buf : live_low; // [RL9]
          next_r.low_frozen = 1'b0;
        end
        OFS_STATUS:     next_r.rdata[STAT_OVF] = r.ovf;
        OFS_CONTROL:    next_r.rdata[3:0] = {r.ovf_ie, r.ext_edge, r.clk_sel};
        OFS_IRQ_MASK:   next_r.rdata[0] = r.irq_mask;
        OFS_IRQ_STATUS: next_r.rdata[0] = r.irq_stat;
        default:        next_r.rdata = 32'h0;
      endcase
    end
    if (rd && avs_address_i == OFS_STATUS && r.ovf) begin
      next_r.clr_st = CLR_ARMED; // [RL12]
    end
    // Only the main low byte completes the clear; alternate low never does
    if (req && avs_address_i == OFS_COUNT_LOW && r.clr_st == CLR_ARMED) begin
      next_r.clr_st = CLR_IDLE;
      if (!(adv && r.count == COUNT_TOP)) begin
        next_r.ovf = 1'b0; // [RL12] [RL13]
      end
    end
    if (wr) begin
      case (avs_address_i)
        OFS_COUNT_LOW, OFS_ALT_LOW: next_r.count = COUNT_RESET; // [RL4]
        OFS_CONTROL: begin
          next_r.clk_sel  = avs_writedata_i[CTRL_CLK_SEL_HI:CTRL_CLK_SEL_LO];
          next_r.ext_edge = avs_writedata_i[CTRL_EXT_EDGE];
          next_r.ovf_ie   = avs_writedata_i[CTRL_OVF_IE];
        end
        OFS_IRQ_MASK: next_r.irq_mask = avs_writedata_i[0];
        OFS_IRQ_STATUS: begin
          if (avs_writedata_i[0] && !(adv && r.count == COUNT_TOP)) begin
            next_r.irq_stat = 1'b0;
          end
        end
        default: next_r.irq_mask = r.irq_mask;
      endcase
    end
    next_r.irq = next_r.ovf & next_r.ovf_ie & ~global_irq_mask_i; // [RL11]
    case (r.clr_st)
      CLR_IDLE, CLR_ARMED: next_r.clr_st = next_r.clr_st;
      default:             next_r.clr_st = CLR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      r            <= '0;
      r.count      <= COUNT_RESET; // [RL5]
      r.clr_st     <= CLR_IDLE;
      r.clk_sel    <= CTRL_RESET[1:0];
      r.ext_sync   <= 3'h7;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_r.irq_stat & next_r.irq_mask;
    end
  end

  assign avs_readdata_o    = r.rdata;
  assign avs_waitrequest_o = ~r.ack;
  assign overflow_irq_o    = r.irq;

  a_reset_value: assert property (@(posedge clk_sys_i)
    $fell(reset_i) |-> r.count == COUNT_RESET) else $error("count not FFFC after reset"); // [RL5]
  a_low_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr && (avs_address_i == OFS_COUNT_LOW || avs_address_i == OFS_ALT_LOW)
    |=> r.count == COUNT_RESET) else $error("low write did not reload"); // [RL4]
  a_wrap_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    adv && !wr && r.count == COUNT_TOP |=> r.ovf && r.count == 16'h0000) else $error("wrap lost"); // [RL10]
  a_halt_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    halt_i && !wr |=> r.count == $past(r.count)) else $error("count moved in halt"); // [RL15]
  a_tick_only: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !r.cpu_tick_q && !wr |=> r.count == $past(r.count)) else $error("count off tick"); // [RL17]
  a_alt_keeps: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req && avs_address_i == OFS_ALT_LOW && r.ovf |=> r.ovf) else $error("alt cleared flag"); // [RL13]
  a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    overflow_irq_o |-> r.ovf_ie && $past(!global_irq_mask_i)) else $error("irq ungated"); // [RL11]
  a_freeze_buf: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    r.low_frozen && !(rd && (avs_address_i == OFS_COUNT_LOW || avs_address_i == OFS_ALT_LOW))
    |=> r.low_buf == $past(r.low_buf)) else $error("buffer changed"); // [RL8]
  a_div2_step: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    adv && !wr |=> r.count == $past(r.count) + 16'h0001) else $error("bad step"); // [RL1]

  // The overflow clear is a two-step handshake, so it is checked step by step
  sequence s_status_arm;
    rd && avs_address_i == OFS_STATUS && r.ovf;
  endsequence

  sequence s_main_low_access;
    req && avs_address_i == OFS_COUNT_LOW && r.clr_st == CLR_ARMED && !(adv && r.count == COUNT_TOP);
  endsequence

  a_clear_arm: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL12]
    s_status_arm |=> r.clr_st == CLR_ARMED) else $error("status read did not arm clear");
  a_ovf_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL12]
    s_main_low_access |=> !r.ovf) else $error("main low access did not clear flag");
  a_one_wait: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req |=> !avs_waitrequest_o) else $error("answer not one cycle after request");
  a_ack_pulse: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low too long");
  a_high_capture: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL7]
    rd && (avs_address_i == OFS_COUNT_HIGH || avs_address_i == OFS_ALT_HIGH) && !r.low_frozen
    |=> r.low_frozen && r.low_buf == $past(r.count[7:0])) else $error("low byte not captured");
  a_live_low: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL9]
    rd && (avs_address_i == OFS_COUNT_LOW || avs_address_i == OFS_ALT_LOW) && !r.low_frozen
    |=> avs_readdata_o[7:0] == $past(r.count[7:0])) else $error("unpaired low not live");
  a_same_view: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL6]
    rd && (avs_address_i == OFS_COUNT_HIGH || avs_address_i == OFS_ALT_HIGH)
    |=> avs_readdata_o[7:0] == $past(r.count[15:8])) else $error("high views differ");
  a_presc_halt: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL15]
    halt_i |=> r.presc == $past(r.presc)) else $error("prescaler moved in halt");
  a_ext_step: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [RL3]
    adv && r.clk_sel == CLK_EXT |-> ext_hit) else $error("ext count without edge");
endmodule
